/* File: verilog/pdcr_pkg.sv */
`default_nettype none
package pdcr_pkg;
    localparam int DATA_W = 8;
    localparam int SEL_W = 2;
    localparam int LUT_DEPTH = 256;

    // Register select codes, high bit first
    localparam logic [1:0] RS_WRITE_PTR = 2'h0;
    localparam logic [1:0] RS_LUT = 2'h1;
    localparam logic [1:0] RS_INDEXED = 2'h2;
    localparam logic [1:0] RS_READ_PTR = 2'h3;

    // Indexed locations
    localparam logic [7:0] IDX_READ_MASK = 8'h00;
    localparam logic [7:0] IDX_CTRL_ZERO = 8'h01;
    localparam logic [7:0] IDX_CTRL_ONE = 8'h05;

    // Reset values, writable bits, empty read value and pointer step
    localparam logic [7:0] CTRL_ZERO_RESET = 8'h00;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] READ_MASK_RESET = 8'h00;
    localparam logic [7:0] CTRL_ZERO_MASK = 8'hfb;
    localparam logic [7:0] CTRL_ONE_MASK = 8'h1e;
    localparam logic [7:0] READ_NONE = 8'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;

    // Field positions in control_reg_zero
    localparam int CR0_FMT_MSB = 7;
    localparam int CR0_FMT_LSB = 4;
    localparam int CR0_PD = 3;
    localparam int CR0_WIDTH = 1;
    localparam int CR0_EXT = 0;

    // Field positions in control_reg_one
    localparam int CR1_BLANK = 4;
    localparam int CR1_CLKA_PD = 3;
    localparam int CR1_CLKB_PD = 2;
    localparam int CR1_SENSE_DIS = 1;

    // Strobe level when idle and synchroniser reset image
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic [11:0] SYNC_RESET = 12'h300;

    typedef enum logic [3:0] {
        FMT_PSEUDO8 = 4'h0,
        FMT_15BIT = 4'h1,
        FMT_DUAL8 = 4'h2,
        FMT_565 = 4'h3,
        FMT_8_TWO_CLK = 4'h4,
        FMT_24_16IN_TWO_CLK = 4'h5,
        FMT_565_8IN_TWO_CLK = 4'h6,
        FMT_24_8IN_THREE_CLK = 4'h7,
        FMT_DUAL24_PACKED = 4'he
    } pdcr_format_t;

    typedef enum logic [1:0] {
        COMP_RED = 2'h0,
        COMP_GREEN = 2'h1,
        COMP_BLUE = 2'h2
    } pdcr_comp_t;

    typedef enum logic [1:0] {
        TGT_NONE = 2'h0,
        TGT_CTRL_ZERO = 2'h1,
        TGT_CTRL_ONE = 2'h2,
        TGT_READ_MASK = 2'h3
    } pdcr_target_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } pdcr_state_t;
endpackage : pdcr_pkg
`default_nettype wire

/* File: verilog/pdcr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pdcr_sync #(
    parameter int WIDTH = 12,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage_one;

    // Two flops per bit, first stage read only by the second
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            stage_one <= RESET_VALUE;
            o_sync <= RESET_VALUE;
        end else if (i_ce) begin
            stage_one <= i_async;
            o_sync <= stage_one;
        end
    end
endmodule : pdcr_sync
`default_nettype wire

/* File: verilog/pdcr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module pdcr_regs
    import pdcr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [SEL_W-1:0] i_register_select,
    input wire logic i_read_n,
    input wire logic i_write_n,
    input wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0] o_data,
    output logic o_data_oe,
    output logic [3:0] o_pixel_format,
    output logic o_format_valid,
    output logic o_device_power_down,
    output logic o_dac_8bit,
    output logic o_ext_access,
    output logic o_blank_pedestal,
    output logic o_synth_a_power_down,
    output logic o_synth_b_power_down,
    output logic o_sense_disable,
    output logic [DATA_W-1:0] o_pixel_read_mask
);
    // Indexed decode shared by reads and writes
    function automatic pdcr_target_t decode_index(input logic [7:0] idx, input logic ext);
        pdcr_target_t tgt;
        tgt = TGT_NONE;
        if (idx == IDX_CTRL_ZERO) begin
            tgt = TGT_CTRL_ZERO;
        end else if (idx == IDX_READ_MASK || !ext) begin
            tgt = TGT_READ_MASK;
        end else if (idx == IDX_CTRL_ONE) begin
            tgt = TGT_CTRL_ONE;
        end
        return tgt;
    endfunction : decode_index

    // Supported pixel format codes
    function automatic logic format_ok(input logic [3:0] code);
        logic ok;
        ok = 1'b0;
        case (code)
            FMT_PSEUDO8, FMT_15BIT, FMT_DUAL8, FMT_565, FMT_8_TWO_CLK: ok = 1'b1;
            FMT_24_16IN_TWO_CLK, FMT_565_8IN_TWO_CLK: ok = 1'b1;
            FMT_24_8IN_THREE_CLK, FMT_DUAL24_PACKED: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : format_ok

    logic [11:0] sync_bus;
    logic [SEL_W-1:0] s_rs;
    logic s_rd_n;
    logic s_wr_n;
    logic [DATA_W-1:0] s_data;
    logic prev_rd_n;
    logic prev_wr_n;
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;

    pdcr_state_t state;
    pdcr_state_t next_state;
    logic [7:0] cr0;
    logic [7:0] next_cr0;
    logic [7:0] cr1;
    logic [7:0] next_cr1;
    logic [7:0] read_mask;
    logic [7:0] next_read_mask;
    logic fmt_valid;
    logic next_fmt_valid;
    logic [7:0] data_out;
    logic [7:0] next_data_out;
    logic data_oe;
    logic next_data_oe;
    pdcr_comp_t wr_comp;
    pdcr_comp_t next_wr_comp;
    pdcr_comp_t rd_comp;
    pdcr_comp_t next_rd_comp;

    logic [7:0] wr_ptr;
    logic [7:0] next_wr_ptr;
    logic [7:0] rd_ptr;
    logic [7:0] next_rd_ptr;
    logic [7:0] hold_red;
    logic [7:0] next_hold_red;
    logic [7:0] hold_green;
    logic [7:0] next_hold_green;

    logic [7:0] lut_red [LUT_DEPTH];
    logic [7:0] lut_green [LUT_DEPTH];
    logic [7:0] lut_blue [LUT_DEPTH];
    logic lut_we;
    logic [7:0] lut_rd_value;
    logic [7:0] read_value;
    pdcr_target_t target;

    pdcr_sync #(
        .WIDTH(12),
        .RESET_VALUE(SYNC_RESET)
    ) u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_async({i_register_select, i_read_n, i_write_n, i_data}),
        .o_sync(sync_bus)
    );

    assign s_rs = sync_bus[11:10];
    assign s_rd_n = sync_bus[9];
    assign s_wr_n = sync_bus[8];
    assign s_data = sync_bus[7:0];
    assign rd_fall = prev_rd_n & ~s_rd_n;
    assign rd_rise = ~prev_rd_n & s_rd_n;
    assign wr_fall = prev_wr_n & ~s_wr_n;
    assign wr_rise = ~prev_wr_n & s_wr_n;
    assign target = decode_index(wr_ptr, cr0[CR0_EXT]);

    // Read data selection
    always_comb begin
        case (rd_comp)
            COMP_RED: lut_rd_value = lut_red[rd_ptr];
            COMP_GREEN: lut_rd_value = lut_green[rd_ptr];
            default: lut_rd_value = lut_blue[rd_ptr];
        endcase
        case (s_rs)
            RS_WRITE_PTR: read_value = wr_ptr;
            RS_READ_PTR: read_value = rd_ptr;
            RS_LUT: read_value = lut_rd_value;
            default: begin
                case (target)
                    TGT_CTRL_ZERO: read_value = cr0;
                    TGT_CTRL_ONE: read_value = cr1;
                    TGT_READ_MASK: read_value = read_mask;
                    default: read_value = READ_NONE;
                endcase
            end
        endcase
    end

    // Host access sequencing
    always_comb begin
        next_state = state;
        next_cr0 = cr0;
        next_cr1 = cr1;
        next_read_mask = read_mask;
        next_fmt_valid = fmt_valid;
        next_data_out = data_out;
        next_data_oe = data_oe;
        next_wr_comp = wr_comp;
        next_rd_comp = rd_comp;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_hold_red = hold_red;
        next_hold_green = hold_green;
        lut_we = 1'b0;
        case (state)
            ST_IDLE: begin
                if (rd_fall) begin
                    next_state = ST_READ;
                    next_data_out = read_value;
                    next_data_oe = 1'b1;
                end else if (wr_fall) begin
                    next_state = ST_WRITE;
                end
            end
            ST_READ: begin
                if (rd_rise) begin
                    next_state = ST_IDLE;
                    next_data_oe = 1'b0;
                    if (s_rs == RS_LUT) begin
                        case (rd_comp)
                            COMP_RED: next_rd_comp = COMP_GREEN;
                            COMP_GREEN: next_rd_comp = COMP_BLUE;
                            default: begin
                                next_rd_comp = COMP_RED;
                                next_rd_ptr = rd_ptr + PTR_STEP;
                            end
                        endcase
                    end
                end
            end
            ST_WRITE: begin
                if (wr_rise) begin
                    next_state = ST_IDLE;
                    case (s_rs)
                        RS_WRITE_PTR: begin
                            next_wr_ptr = s_data;
                            next_wr_comp = COMP_RED;
                        end
                        RS_READ_PTR: begin
                            next_rd_ptr = s_data;
                            next_rd_comp = COMP_RED;
                        end
                        RS_LUT: begin
                            case (wr_comp)
                                COMP_RED: begin
                                    next_hold_red = s_data;
                                    next_wr_comp = COMP_GREEN;
                                end
                                COMP_GREEN: begin
                                    next_hold_green = s_data;
                                    next_wr_comp = COMP_BLUE;
                                end
                                default: begin
                                    lut_we = 1'b1;
                                    next_wr_comp = COMP_RED;
                                    next_wr_ptr = wr_ptr + PTR_STEP;
                                end
                            endcase
                        end
                        default: begin
                            case (target)
                                TGT_CTRL_ZERO: begin
                                    next_cr0 = s_data & CTRL_ZERO_MASK;
                                    next_fmt_valid = format_ok(s_data[CR0_FMT_MSB:CR0_FMT_LSB]);
                                end
                                TGT_CTRL_ONE: next_cr1 = s_data & CTRL_ONE_MASK;
                                TGT_READ_MASK: next_read_mask = s_data;
                                default: next_cr0 = cr0;
                            endcase
                        end
                    endcase
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_data_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= ST_IDLE;
            prev_rd_n <= STROBE_IDLE;
            prev_wr_n <= STROBE_IDLE;
            cr0 <= CTRL_ZERO_RESET;
            cr1 <= CTRL_ONE_RESET;
            read_mask <= READ_MASK_RESET;
            fmt_valid <= 1'b1;
            data_out <= READ_NONE;
            data_oe <= 1'b0;
            wr_comp <= COMP_RED;
            rd_comp <= COMP_RED;
        end else if (i_ce) begin
            state <= next_state;
            prev_rd_n <= s_rd_n;
            prev_wr_n <= s_wr_n;
            cr0 <= next_cr0;
            cr1 <= next_cr1;
            read_mask <= next_read_mask;
            fmt_valid <= next_fmt_valid;
            data_out <= next_data_out;
            data_oe <= next_data_oe;
            wr_comp <= next_wr_comp;
            rd_comp <= next_rd_comp;
        end
    end

    // Pointers, holding bytes and table keep their contents through reset
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            hold_red <= next_hold_red;
            hold_green <= next_hold_green;
            if (lut_we) begin
                lut_red[wr_ptr] <= hold_red;
                lut_green[wr_ptr] <= hold_green;
                lut_blue[wr_ptr] <= s_data;
            end
        end
    end

    assign o_data = data_out;
    assign o_data_oe = data_oe;
    assign o_pixel_format = cr0[CR0_FMT_MSB:CR0_FMT_LSB];
    assign o_format_valid = fmt_valid;
    assign o_device_power_down = cr0[CR0_PD];
    assign o_dac_8bit = cr0[CR0_WIDTH];
    assign o_ext_access = cr0[CR0_EXT];
    assign o_blank_pedestal = cr1[CR1_BLANK];
    assign o_synth_a_power_down = cr1[CR1_CLKA_PD];
    assign o_synth_b_power_down = cr1[CR1_CLKB_PD];
    assign o_sense_disable = cr1[CR1_SENSE_DIS];
    assign o_pixel_read_mask = read_mask;

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_commit(logic [1:0] sel);
        state == ST_WRITE && wr_rise && i_ce && s_rs == sel;
    endsequence
    sequence s_read_start;
        state == ST_IDLE && rd_fall && i_ce;
    endsequence

    property p_wptr_load;
        s_commit(RS_WRITE_PTR) |=> wr_ptr == $past(s_data) && wr_comp == COMP_RED;
    endproperty
    a_wptr_load: assert property (p_wptr_load) else $error("write pointer not loaded");

    property p_rptr_load;
        s_commit(RS_READ_PTR) |=> rd_ptr == $past(s_data) && rd_comp == COMP_RED;
    endproperty
    a_rptr_load: assert property (p_rptr_load) else $error("read pointer not loaded");

    property p_cr0_load;
        s_commit(RS_INDEXED) ##0 (wr_ptr == IDX_CTRL_ZERO)
            |=> cr0 == ($past(s_data) & CTRL_ZERO_MASK);
    endproperty
    a_cr0_load: assert property (p_cr0_load) else $error("control zero not loaded");

    property p_cr1_load;
        s_commit(RS_INDEXED) ##0 (wr_ptr == IDX_CTRL_ONE && cr0[CR0_EXT])
            |=> cr1 == ($past(s_data) & CTRL_ONE_MASK);
    endproperty
    a_cr1_load: assert property (p_cr1_load) else $error("control one not loaded");

    property p_power_down;
        s_commit(RS_INDEXED) ##0 (wr_ptr == IDX_CTRL_ZERO && s_data[CR0_PD])
            |=> o_device_power_down ##1 o_device_power_down || state != ST_IDLE;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power down not set");

    property p_fmt_valid;
        o_format_valid == format_ok(o_pixel_format);
    endproperty
    a_fmt_valid: assert property (p_fmt_valid) else $error("format flag mismatch");

    property p_reserved_zero;
        (cr0 & ~CTRL_ZERO_MASK) == READ_NONE && (cr1 & ~CTRL_ONE_MASK) == READ_NONE;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_lut_step;
        s_commit(RS_LUT) ##0 (wr_comp == COMP_BLUE)
            |=> wr_ptr == $past(wr_ptr) + PTR_STEP && wr_comp == COMP_RED;
    endproperty
    a_lut_step: assert property (p_lut_step) else $error("table location not stepped");

    property p_mask_route;
        s_commit(RS_INDEXED) ##0 (!cr0[CR0_EXT] && wr_ptr != IDX_CTRL_ZERO)
            |=> o_pixel_read_mask == $past(s_data) && $stable(cr1);
    endproperty
    a_mask_route: assert property (p_mask_route) else $error("mask not written");

    property p_read_drive;
        s_read_start |=> o_data_oe && o_data == $past(read_value);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");
endmodule : pdcr_regs
`default_nettype wire

/* File: verif/pdcr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pdcr_host_model
    import pdcr_pkg::*;
(
    input wire logic i_clk,
    input wire logic [DATA_W-1:0] i_dev_data,
    input wire logic i_dev_oe,
    output logic [SEL_W-1:0] o_register_select,
    output logic o_read_n,
    output logic o_write_n,
    output logic [DATA_W-1:0] o_pin_data
);
    logic [DATA_W-1:0] drive_data;
    logic drive_en;
    logic [DATA_W-1:0] last_level;

    initial begin
        o_register_select = RS_WRITE_PTR;
        o_read_n = 1'b1;
        o_write_n = 1'b1;
        drive_data = 8'h00;
        drive_en = 1'b0;
        last_level = 8'h00;
    end

    // Released pins show the inverse of the last level
    always_comb begin
        if (drive_en) begin
            o_pin_data = drive_data;
        end else if (i_dev_oe) begin
            o_pin_data = i_dev_data;
        end else begin
            o_pin_data = ~last_level;
        end
    end

    always @(posedge i_clk) begin
        if (drive_en || i_dev_oe) begin
            last_level <= o_pin_data;
        end
    end

    // Select and data held well past the strobe rise
    task automatic write_cycle(input logic [1:0] sel, input logic [7:0] val);
        @(posedge i_clk);
        o_register_select <= sel;
        drive_data <= val;
        drive_en <= 1'b1;
        o_write_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_write_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        drive_en <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : write_cycle

    task automatic read_cycle(input logic [1:0] sel, output logic [7:0] val);
        int n;
        n = 0;
        val = 'x;
        @(posedge i_clk);
        o_register_select <= sel;
        o_read_n <= 1'b0;
        @(posedge i_clk);
        while (i_dev_oe !== 1'b1 && n < 12) begin
            @(posedge i_clk);
            n++;
        end
        if (n < 12) begin
            val = i_dev_data;
        end
        o_read_n <= 1'b1;
        n = 0;
        @(posedge i_clk);
        while (i_dev_oe !== 1'b0 && n < 12) begin
            @(posedge i_clk);
            n++;
        end
        repeat (3) @(posedge i_clk);
    endtask : read_cycle
endmodule : pdcr_host_model
`default_nettype wire

/* File: verif/tb_pdcr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pdcr_regs
    import pdcr_pkg::*;
;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] val;
        logic [7:0] exp;
    } pdcr_row_t;

    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_ce = 1'b1;
    logic [1:0] sel;
    logic rd_n;
    logic wr_n;
    logic [7:0] pin_data;
    logic [7:0] o_data;
    logic o_data_oe;
    logic [3:0] o_pixel_format;
    logic o_format_valid;
    logic o_device_power_down;
    logic o_dac_8bit;
    logic o_ext_access;
    logic o_blank_pedestal;
    logic o_synth_a_power_down;
    logic o_synth_b_power_down;
    logic o_sense_disable;
    logic [7:0] o_pixel_read_mask;
    int err_total = 0;
    int check_count = 0;
    int cycle_count = 0;
    logic [7:0] exp_cr0;
    logic [7:0] exp_cr1;
    logic [7:0] exp_mask;
    logic [7:0] rd;
    pdcr_row_t rows [0:7] = '{'{8'h01, 8'h1f, 8'h1b}, '{8'h05, 8'hff, 8'h1e},
        '{8'h05, 8'h12, 8'h12}, '{8'h00, 8'h5a, 8'h5a}, '{8'h02, 8'h44, 8'h00},
        '{8'h01, 8'h02, 8'h02}, '{8'h05, 8'h77, 8'h77}, '{8'h03, 8'hc3, 8'hc3}};

    always #10 i_clk = ~i_clk;

    pdcr_regs u_pdcr_regs (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
        .i_register_select(sel), .i_read_n(rd_n), .i_write_n(wr_n), .i_data(pin_data),
        .o_data(o_data), .o_data_oe(o_data_oe), .o_pixel_format(o_pixel_format),
        .o_format_valid(o_format_valid), .o_device_power_down(o_device_power_down),
        .o_dac_8bit(o_dac_8bit), .o_ext_access(o_ext_access),
        .o_blank_pedestal(o_blank_pedestal), .o_synth_a_power_down(o_synth_a_power_down),
        .o_synth_b_power_down(o_synth_b_power_down), .o_sense_disable(o_sense_disable),
        .o_pixel_read_mask(o_pixel_read_mask));

    pdcr_host_model u_pdcr_host_model (.i_clk(i_clk), .i_dev_data(o_data),
        .i_dev_oe(o_data_oe), .o_register_select(sel), .o_read_n(rd_n),
        .o_write_n(wr_n), .o_pin_data(pin_data));

    task automatic final_report();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    always @(posedge i_clk) begin
        cycle_count++;
        if (cycle_count >= 5000) begin
            err_total++;
            final_report();
        end
    end

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_outputs();
        check_byte({o_pixel_format, o_device_power_down, 1'b0, o_dac_8bit, o_ext_access},
            exp_cr0);
        check_byte({3'h0, o_blank_pedestal, o_synth_a_power_down, o_synth_b_power_down,
            o_sense_disable, 1'b0}, exp_cr1);
        check_byte(o_pixel_read_mask, exp_mask);
    endtask : check_outputs

    task automatic do_reset();
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_clk);
        exp_cr0 = 8'h00;
        exp_cr1 = 8'h00;
        exp_mask = 8'h00;
    endtask : do_reset

    // Decode of indexed place; 0 none, 1 zero, 2 one, 3 mask
    function automatic int target(input logic [7:0] idx);
        if (idx == 8'h01) return 1;
        if (exp_cr0[0] == 1'b0 || idx == 8'h00) return 3;
        if (idx == 8'h05) return 2;
        return 0;
    endfunction : target

    task automatic index_write(input logic [7:0] idx, input logic [7:0] val);
        int t;
        t = target(idx);
        u_pdcr_host_model.write_cycle(RS_WRITE_PTR, idx);
        u_pdcr_host_model.write_cycle(RS_INDEXED, val);
        if (t == 1) exp_cr0 = val & 8'hfb;
        if (t == 2) exp_cr1 = val & 8'h1e;
        if (t == 3) exp_mask = val;
    endtask : index_write

    function automatic logic [7:0] index_value(input logic [7:0] idx);
        case (target(idx))
            1: return exp_cr0;
            2: return exp_cr1;
            3: return exp_mask;
            default: return 8'h00;
        endcase
    endfunction : index_value

    initial begin
        exp_cr0 = 8'h00;
        exp_cr1 = 8'h00;
        exp_mask = 8'h00;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_clk);
        check_outputs();
        check_bit(o_data_oe, 1'b0);
        check_bit(o_format_valid, 1'b1);
        check_byte(o_data, READ_NONE);
        // Pointers survive a reset
        u_pdcr_host_model.write_cycle(RS_WRITE_PTR, 8'ha5);
        u_pdcr_host_model.write_cycle(RS_READ_PTR, 8'h3c);
        do_reset();
        check_outputs();
        u_pdcr_host_model.read_cycle(RS_WRITE_PTR, rd);
        check_byte(rd, 8'ha5);
        u_pdcr_host_model.read_cycle(RS_READ_PTR, rd);
        check_byte(rd, 8'h3c);
        // Indexed rows, reserved bits written as ones on purpose
        foreach (rows[i]) begin
            index_write(rows[i].idx, rows[i].val);
            u_pdcr_host_model.read_cycle(RS_INDEXED, rd);
            check_byte(rd, index_value(rows[i].idx));
            check_byte(rd, rows[i].exp);
            check_outputs();
        end
        // Every format code, reserved ones included on purpose
        for (int c = 0; c < 16; c++) begin
            index_write(IDX_CTRL_ZERO, {c[3:0], 4'h1});
            check_outputs();
            check_bit(o_format_valid, c < 8 || c == 14);
        end
        // Clock enable low freezes the block through a whole write
        @(posedge i_clk);
        i_ce <= 1'b0;
        u_pdcr_host_model.write_cycle(RS_INDEXED, 8'h0a);
        i_ce <= 1'b1;
        repeat (4) @(posedge i_clk);
        check_outputs();
        check_bit(o_format_valid, 1'b0);
        // Reset clears registers that now hold non-zero values
        do_reset();
        check_outputs();
        check_bit(o_format_valid, 1'b1);
        check_byte(o_data, READ_NONE);
        check_bit(o_data_oe, 1'b0);
        // Colour table triplets with pointer stepping
        u_pdcr_host_model.write_cycle(RS_WRITE_PTR, 8'h10);
        for (int i = 0; i < 6; i++) begin
            u_pdcr_host_model.write_cycle(RS_LUT, 8'h90 + 8'(i * 7));
        end
        u_pdcr_host_model.write_cycle(RS_READ_PTR, 8'h10);
        for (int i = 0; i < 6; i++) begin
            u_pdcr_host_model.read_cycle(RS_LUT, rd);
            check_byte(rd, 8'h90 + 8'(i * 7));
        end
        u_pdcr_host_model.read_cycle(RS_WRITE_PTR, rd);
        check_byte(rd, 8'h12);
        u_pdcr_host_model.read_cycle(RS_READ_PTR, rd);
        check_byte(rd, 8'h12);
        final_report();
    end
endmodule : tb_pdcr_regs
`default_nettype wire
